//--- inc/tsc_pkg.sv
package tsc_pkg;

  // register map on the parallel port; addr[13] high is memory space
  localparam logic [13:0] BANK_MASK = 14'h3fe0;
  localparam logic [13:0] SYSCTL_ADDR = 14'h0000;
  localparam logic [13:0] IN_CTRL_BASE = 14'h0100;
  localparam logic [13:0] IN_QUAD_BASE = 14'h0120;
  localparam logic [13:0] OUT_CTRL_BASE = 14'h0140;
  localparam logic [13:0] BER_START_BASE = 14'h0300;
  localparam logic [13:0] BER_LEN_BASE = 14'h0320;
  localparam logic [13:0] BER_CTRL_BASE = 14'h0340;
  localparam logic [13:0] BER_ERR_BASE = 14'h0360;

  // writable bits of each register; the rest read as zero
  localparam logic [15:0] IN_CTRL_MASK = 16'h01ff;
  localparam logic [15:0] IN_QUAD_MASK = 16'h0fff;
  localparam logic [15:0] OUT_CTRL_MASK = 16'h0fff;
  localparam logic [15:0] BER_START_MASK = 16'h00ff;
  localparam logic [15:0] BER_LEN_MASK = 16'h01ff;
  localparam logic [15:0] BER_CTRL_MASK = 16'h0001;
  localparam logic [15:0] SYSCTL_MASK = 16'h0001;
  localparam int BER_START_POS = 0;
  localparam int BER_GLOBAL_EN_POS = 0;
  localparam logic [15:0] REG_RST = 16'h0000;

  // test pattern generator, x^15 + x^14 + 1
  localparam logic [14:0] PRBS_SEED = 15'h7fff;
  localparam logic [15:0] ERR_MAX = 16'hffff;

  // rate codes: 1 = 2.048, 2 = 4.096, 3 = 8.192, 4 = 16.384 Mbps
  localparam logic [3:0] RATE_MIN = 4'h1;
  localparam logic [3:0] RATE_MAX = 4'h4;

  typedef enum logic [1:0] {
    BER_IDLE = 2'b00,
    BER_ARM = 2'b01,
    BER_RUN = 2'b11
  } tsc_ber_e;

  typedef struct packed {
    logic [3:0] in_rate;
    logic [11:0] quad;
    logic [3:0] out_rate;
    logic [7:0] start_ch;
    logic [8:0] length;
  } tsc_cfg_s;

endpackage : tsc_pkg

//--- verilog/tsc_lane.sv
`timescale 1ns/1ps
module tsc_lane (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // frame timing, one tick per 16.384 Mbps bit time
  input wire logic [10:0] tick_in,
  input wire logic tick_en_in,
  // configuration
  input wire tsc_pkg::tsc_cfg_s cfg_in,
  input wire logic ber_on_in,
  // serial data
  input wire logic rx_bit_in,
  input wire logic sw_bit_in,
  input wire logic ber_sel_in,
  output logic fwd_out,
  output logic tx_out,
  output logic [15:0] err_cnt_out
);

  logic in_ok, out_ok, in_slot, out_slot, in_win, cmp, forced;
  logic [1:0] in_s, out_s, in_q;
  logic [10:0] in_sh;
  logic [7:0] in_ch;
  logic [2:0] in_bi, qcode;
  logic [8:0] rel;
  logic [14:0] rx_prbs_q, tx_prbs_q;
  tsc_pkg::tsc_ber_e state_q;

  // slower rates take one bit every 2^s ticks
  assign in_ok = cfg_in.in_rate >= tsc_pkg::RATE_MIN && cfg_in.in_rate <= tsc_pkg::RATE_MAX;
  assign out_ok = cfg_in.out_rate >= tsc_pkg::RATE_MIN && cfg_in.out_rate <= tsc_pkg::RATE_MAX;
  assign in_s = 2'(3'h4 - cfg_in.in_rate[2:0]);
  assign out_s = 2'(3'h4 - cfg_in.out_rate[2:0]);
  assign in_slot = tick_en_in && in_ok && ((tick_in & ~(11'h7ff << in_s)) == 11'h000);
  assign out_slot = tick_en_in && out_ok && ((tick_in & ~(11'h7ff << out_s)) == 11'h000);
  assign in_sh = tick_in >> in_s;
  assign in_ch = in_sh[10:3];
  assign in_bi = in_sh[2:0];
  assign in_q = 2'(in_ch >> (cfg_in.in_rate[2:0] + 3'h2));

  always_comb begin
    case (in_q)
      2'h0: qcode = cfg_in.quad[2:0];
      2'h1: qcode = cfg_in.quad[5:3];
      2'h2: qcode = cfg_in.quad[8:6];
      default: qcode = cfg_in.quad[11:9];
    endcase
  end

  // data is msb first, so bit index 0 is the msb and 7 the lsb
  always_comb begin
    forced = rx_bit_in;
    if (qcode[2] && qcode[1] && in_bi == 3'h0) forced = qcode[0];
    if (qcode[2] && !qcode[1] && in_bi == 3'h7) forced = qcode[0];
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) fwd_out <= 1'b0;
    else if (in_slot) fwd_out <= forced;
  end

  // run starts on a frame boundary so the pattern lines up with the window
  always_ff @(posedge clk_in) begin
    if (!rstn_in) state_q <= tsc_pkg::BER_IDLE;
    else if (!ber_on_in) state_q <= tsc_pkg::BER_IDLE;
    else begin
      case (state_q)
        tsc_pkg::BER_IDLE: state_q <= tsc_pkg::BER_ARM;
        tsc_pkg::BER_ARM: if (tick_en_in && tick_in == 11'h000) state_q <= tsc_pkg::BER_RUN;
        tsc_pkg::BER_RUN: state_q <= tsc_pkg::BER_RUN;
        default: state_q <= tsc_pkg::BER_IDLE;
      endcase
    end
  end

  assign rel = 9'({1'b0, in_ch} - {1'b0, cfg_in.start_ch});
  assign in_win = in_ch >= cfg_in.start_ch && rel < cfg_in.length;
  assign cmp = in_slot && state_q == tsc_pkg::BER_RUN && in_win;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) rx_prbs_q <= tsc_pkg::PRBS_SEED;
    else if (state_q != tsc_pkg::BER_RUN) rx_prbs_q <= tsc_pkg::PRBS_SEED;
    else if (cmp) rx_prbs_q <= {rx_prbs_q[13:0], rx_prbs_q[14] ^ rx_prbs_q[13]};
  end

  // count saturates rather than wrap, so a long bad run never reads low
  always_ff @(posedge clk_in) begin
    if (!rstn_in) err_cnt_out <= 16'h0000;
    else if (state_q == tsc_pkg::BER_IDLE && ber_on_in) err_cnt_out <= 16'h0000;
    else if (cmp && rx_bit_in != rx_prbs_q[14] && err_cnt_out != tsc_pkg::ERR_MAX)
      err_cnt_out <= err_cnt_out + 16'h0001;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) tx_prbs_q <= tsc_pkg::PRBS_SEED;
    else if (out_slot && ber_sel_in) tx_prbs_q <= {tx_prbs_q[13:0], tx_prbs_q[14] ^ tx_prbs_q[13]};
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) tx_out <= 1'b0;
    else if (!out_ok) tx_out <= 1'b0;
    else if (out_slot) tx_out <= ber_sel_in ? tx_prbs_q[14] : sw_bit_in;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_arm;
    state_q == tsc_pkg::BER_IDLE && ber_on_in ##1 state_q == tsc_pkg::BER_ARM;
  endsequence

  force_lsb_a: assert property (in_slot && qcode == 3'b100 && in_bi == 3'h7 |=> !fwd_out)
    else $error("lsb not forced low");
  force_msb_a: assert property (in_slot && qcode == 3'b111 && in_bi == 3'h0 |=> fwd_out)
    else $error("msb not forced high");
  quad_pass_a: assert property (in_slot && !qcode[2] |=> fwd_out == $past(rx_bit_in))
    else $error("normal quadrant altered data");
  arm_clear_a: assert property (s_arm |-> err_cnt_out == 16'h0000)
    else $error("error count not cleared at test start");
  err_step_a: assert property (cmp && rx_bit_in != rx_prbs_q[14] && err_cnt_out != 16'hffff
    |=> err_cnt_out == $past(err_cnt_out) + 16'h0001)
    else $error("error not counted");
  win_only_a: assert property (!cmp ##0 state_q != tsc_pkg::BER_IDLE
    |=> err_cnt_out == $past(err_cnt_out))
    else $error("count moved outside window");
  off_idle_a: assert property (!ber_on_in |=> state_q == tsc_pkg::BER_IDLE)
    else $error("test kept running while off");
  tx_pattern_a: assert property (out_slot && ber_sel_in |=> tx_out == $past(tx_prbs_q[14]))
    else $error("pattern not sent");

endmodule : tsc_lane

//--- verilog/tsc_stream_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - per-quadrant 3-bit code forces channel LSB/MSB
// - start bit begins BER test on stream when the global enable is set
// - 16-bit read-only per-stream error count
// - 32 copies per family, contiguous word ranges
// - channel count follows stream rate
// - ber_sel_in high sends test pattern on the stream output
module tsc_stream_ctrl #(
  parameter int N_STREAMS = 32
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // parallel register port, same clock
  input wire logic cpu_cs_in,
  input wire logic cpu_we_in,
  input wire logic [13:0] cpu_addr_in,
  input wire logic [15:0] cpu_wdata_in,
  output logic [15:0] cpu_rdata_out,
  output logic cpu_ack_out,
  // serial frame timing from pins
  input wire logic bit_clk_in,
  input wire logic frame_in,
  // serial streams
  input wire logic [N_STREAMS-1:0] sti_in,
  output logic [N_STREAMS-1:0] sto_out,
  // switch core side
  input wire logic [N_STREAMS-1:0] sw_data_in,
  input wire logic [N_STREAMS-1:0] ber_sel_in,
  output logic [N_STREAMS-1:0] fwd_data_out
);

  logic bclk_s1, bclk_s2, bclk_s3, fp_s1, fp_s2, edge_w;
  logic [N_STREAMS-1:0] sti_s1, sti_s2, rx_q;
  logic [10:0] tick_q;
  logic tick_en_q;
  logic [15:0] sysctl_q;
  logic [15:0] in_ctrl_q [N_STREAMS];
  logic [15:0] in_quad_q [N_STREAMS];
  logic [15:0] out_ctrl_q [N_STREAMS];
  logic [15:0] ber_start_q [N_STREAMS];
  logic [15:0] ber_len_q [N_STREAMS];
  logic [15:0] ber_ctrl_q [N_STREAMS];
  logic [15:0] err_w [N_STREAMS];
  logic [13:0] bank;
  logic [4:0] idx;

  // pins cross into clk_in through two flops before any logic
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      bclk_s1 <= 1'b0;
      bclk_s2 <= 1'b0;
      bclk_s3 <= 1'b0;
      fp_s1 <= 1'b0;
      fp_s2 <= 1'b0;
      sti_s1 <= '0;
      sti_s2 <= '0;
    end else begin
      bclk_s1 <= bit_clk_in;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      fp_s1 <= frame_in;
      fp_s2 <= fp_s1;
      sti_s1 <= sti_in;
      sti_s2 <= sti_s1;
    end
  end

  assign edge_w = bclk_s2 && !bclk_s3;

  // the bit clock must be slower than clk_in/4 for edges to be seen
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tick_q <= 11'h000;
      tick_en_q <= 1'b0;
      rx_q <= '0;
    end else begin
      tick_en_q <= edge_w;
      if (edge_w) begin
        tick_q <= fp_s2 ? 11'h000 : tick_q + 11'h001;
        rx_q <= sti_s2;
      end
    end
  end

  assign bank = cpu_addr_in & tsc_pkg::BANK_MASK;
  assign idx = cpu_addr_in[4:0];

  // writes to the error count bank fall through: it is read only
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sysctl_q <= tsc_pkg::REG_RST;
      for (int i = 0; i < N_STREAMS; i++) begin
        in_ctrl_q[i] <= tsc_pkg::REG_RST;
        in_quad_q[i] <= tsc_pkg::REG_RST;
        out_ctrl_q[i] <= tsc_pkg::REG_RST;
        ber_start_q[i] <= tsc_pkg::REG_RST;
        ber_len_q[i] <= tsc_pkg::REG_RST;
        ber_ctrl_q[i] <= tsc_pkg::REG_RST;
      end
    end else if (cpu_cs_in && cpu_we_in && !cpu_addr_in[13]) begin
      if (cpu_addr_in == tsc_pkg::SYSCTL_ADDR)
        sysctl_q <= cpu_wdata_in & tsc_pkg::SYSCTL_MASK;
      case (bank)
        tsc_pkg::IN_CTRL_BASE: in_ctrl_q[idx] <= cpu_wdata_in & tsc_pkg::IN_CTRL_MASK;
        tsc_pkg::IN_QUAD_BASE: in_quad_q[idx] <= cpu_wdata_in & tsc_pkg::IN_QUAD_MASK;
        tsc_pkg::OUT_CTRL_BASE: out_ctrl_q[idx] <= cpu_wdata_in & tsc_pkg::OUT_CTRL_MASK;
        tsc_pkg::BER_START_BASE: ber_start_q[idx] <= cpu_wdata_in & tsc_pkg::BER_START_MASK;
        tsc_pkg::BER_LEN_BASE: ber_len_q[idx] <= cpu_wdata_in & tsc_pkg::BER_LEN_MASK;
        tsc_pkg::BER_CTRL_BASE: ber_ctrl_q[idx] <= cpu_wdata_in & tsc_pkg::BER_CTRL_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cpu_rdata_out <= 16'h0000;
      cpu_ack_out <= 1'b0;
    end else begin
      cpu_ack_out <= cpu_cs_in;
      if (cpu_cs_in && !cpu_we_in) begin
        if (cpu_addr_in[13]) cpu_rdata_out <= 16'h0000;
        else if (cpu_addr_in == tsc_pkg::SYSCTL_ADDR) cpu_rdata_out <= sysctl_q;
        else begin
          case (bank)
            tsc_pkg::IN_CTRL_BASE: cpu_rdata_out <= in_ctrl_q[idx];
            tsc_pkg::IN_QUAD_BASE: cpu_rdata_out <= in_quad_q[idx];
            tsc_pkg::OUT_CTRL_BASE: cpu_rdata_out <= out_ctrl_q[idx];
            tsc_pkg::BER_START_BASE: cpu_rdata_out <= ber_start_q[idx];
            tsc_pkg::BER_LEN_BASE: cpu_rdata_out <= ber_len_q[idx];
            tsc_pkg::BER_CTRL_BASE: cpu_rdata_out <= ber_ctrl_q[idx];
            tsc_pkg::BER_ERR_BASE: cpu_rdata_out <= err_w[idx];
            default: cpu_rdata_out <= 16'h0000;
          endcase
        end
      end
    end
  end

  for (genvar g = 0; g < N_STREAMS; g++) begin : g_lane
    tsc_pkg::tsc_cfg_s cfg;
    logic on;
    assign cfg.in_rate = in_ctrl_q[g][3:0];
    assign cfg.quad = in_quad_q[g][11:0];
    assign cfg.out_rate = out_ctrl_q[g][3:0];
    assign cfg.start_ch = ber_start_q[g][7:0];
    assign cfg.length = ber_len_q[g][8:0];
    // a start bit without the global enable is held off
    assign on = ber_ctrl_q[g][tsc_pkg::BER_START_POS] && sysctl_q[tsc_pkg::BER_GLOBAL_EN_POS];
    tsc_lane u_lane (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .tick_in(tick_q),
      .tick_en_in(tick_en_q),
      .cfg_in(cfg),
      .ber_on_in(on),
      .rx_bit_in(rx_q[g]),
      .sw_bit_in(sw_data_in[g]),
      .ber_sel_in(ber_sel_in[g]),
      .fwd_out(fwd_data_out[g]),
      .tx_out(sto_out[g]),
      .err_cnt_out(err_w[g])
    );
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  bus_ack_a: assert property (cpu_cs_in |=> cpu_ack_out)
    else $error("access not acknowledged");
  mem_zero_a: assert property (cpu_cs_in && !cpu_we_in && cpu_addr_in[13] |=> cpu_rdata_out == 16'h0000)
    else $error("memory space read not zero");
  err_read_a: assert property (cpu_cs_in && !cpu_we_in && bank == tsc_pkg::BER_ERR_BASE
    && !cpu_addr_in[13] |=> cpu_rdata_out == $past(err_w[0]) || $past(idx) != 5'h00)
    else $error("error count read wrong");
  tick_pulse_a: assert property (tick_en_q |=> !tick_en_q)
    else $error("tick longer than one cycle");

endmodule : tsc_stream_ctrl

//--- tb/tsc_tdm_partner.sv
`timescale 1ns/1ps
module tsc_tdm_partner (
  // idle line levels and test pattern control
  input wire logic [31:0] lvl_in,
  input wire logic arm_in,
  input wire logic [3:0] err_n_in,
  // serial timing and data
  output logic bit_clk_out,
  output logic frame_out,
  output logic [31:0] sti_out,
  output logic [10:0] idx_out
);
  // pattern stream and its window: channels 10 to 13 at the top rate
  localparam int BER_S = 5;
  localparam int WIN_LO = 80;
  localparam int WIN_HI = 112;
  logic [14:0] r;
  logic run;
  int k;
  // bit clock runs free; data changes on the falling edge, away from sampling
  initial begin
    bit_clk_out = 1'b1;
    frame_out = 1'b0;
    sti_out = 32'h0;
    idx_out = 11'h7ff;
    run = 1'b0;
    r = 15'h7fff;
    k = 0;
    #37;
    forever begin
      #400;
      bit_clk_out = 1'b0;
      idx_out = idx_out + 11'h1;
      frame_out = (idx_out == 11'h0);
      if (!arm_in) run = 1'b0;
      // a new run restarts the pattern at the next frame only
      if (frame_out && arm_in && !run) begin
        run = 1'b1;
        r = 15'h7fff;
        k = 0;
      end
      sti_out = lvl_in;
      if (run && idx_out >= WIN_LO && idx_out < WIN_HI) begin
        sti_out[BER_S] = r[14] ^ (k < int'(err_n_in));
        r = {r[13:0], r[14] ^ r[13]};
        k++;
      end
      #400;
      bit_clk_out = 1'b1;
    end
  end
endmodule : tsc_tdm_partner

//--- tb/tdm_stream_ctrl_ber_receiver_tb.sv
`timescale 1ns/1ps
module tdm_stream_ctrl_ber_receiver_tb;
  localparam logic [31:0] LVL = 32'h0000000e;
  logic clk_in, rstn_in, cpu_cs_in, cpu_we_in, cpu_ack_out, bit_clk, frame, arm;
  logic [13:0] cpu_addr_in;
  logic [15:0] cpu_wdata_in, cpu_rdata_out, rd;
  logic [31:0] sti, sto_out, fwd_data_out, sw_data_in, ber_sel_in;
  logic [10:0] idx;
  logic [3:0] err_n;
  logic [7:0] fb;
  logic [63:0] ob;
  int error_cnt, n_compared, cyc;
  logic [13:0] ra [10] = '{14'h0000, 14'h0103, 14'h0123, 14'h0143, 14'h031f,
    14'h0320, 14'h035f, 14'h0360, 14'h0200, 14'h2005};
  logic [15:0] rx [10] = '{16'h0001, 16'h01ff, 16'h0fff, 16'h0fff, 16'h00ff,
    16'h01ff, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
  logic [11:0] qv [5] = '{12'hb6d, 12'hfff, 12'h924, 12'hdb6, 12'hf5c};

  tsc_stream_ctrl u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .cpu_cs_in(cpu_cs_in),
    .cpu_we_in(cpu_we_in), .cpu_addr_in(cpu_addr_in), .cpu_wdata_in(cpu_wdata_in),
    .cpu_rdata_out(cpu_rdata_out), .cpu_ack_out(cpu_ack_out), .bit_clk_in(bit_clk),
    .frame_in(frame), .sti_in(sti), .sto_out(sto_out), .sw_data_in(sw_data_in),
    .ber_sel_in(ber_sel_in), .fwd_data_out(fwd_data_out));
  tsc_tdm_partner u_far (.lvl_in(LVL), .arm_in(arm), .err_n_in(err_n),
    .bit_clk_out(bit_clk), .frame_out(frame), .sti_out(sti), .idx_out(idx));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask : chk_bit

  task automatic acc(input logic we, input logic [13:0] a, input logic [15:0] wd);
    @(posedge clk_in);
    cpu_cs_in <= 1'b1;
    cpu_we_in <= we;
    cpu_addr_in <= a;
    cpu_wdata_in <= wd;
    @(posedge clk_in);
    cpu_cs_in <= 1'b0;
    #1;
    chk_bit(cpu_ack_out, 1'b1);
    rd = cpu_rdata_out;
  endtask : acc

  task automatic rchk(input logic [13:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0);
    chk(rd, exp);
  endtask : rchk

  function automatic logic [7:0] forced(input logic [2:0] code, input logic lvl);
    logic [7:0] b;
    b = {8{lvl}};
    if (code[2] && code[1]) b[7] = code[0];
    if (code[2] && !code[1]) b[0] = code[0];
    return b;
  endfunction : forced

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  // two frame waits plus the fork can reach about 50000 cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    rstn_in = 1'b0;
    cpu_cs_in = 1'b0;
    cpu_we_in = 1'b0;
    cpu_addr_in = 14'h0;
    cpu_wdata_in = 16'h0;
    sw_data_in = 32'h80;
    ber_sel_in = 32'h40;
    arm = 1'b0;
    err_n = 4'h3;
    error_cnt = 0;
    n_compared = 0;
    cyc = 0;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    // row 0 sets the global enable before any start bit
    for (int i = 0; i < 10; i++) begin
      rchk(ra[i], 16'h0);
      acc(1'b1, ra[i], 16'hffff);
      rchk(ra[i], rx[i]);
    end
    $display("test registers done");
    for (int s = 0; s < 6; s++) acc(1'b1, tsc_pkg::IN_CTRL_BASE + 14'(s), 16'h4);
    for (int s = 0; s < 5; s++) acc(1'b1, tsc_pkg::IN_QUAD_BASE + 14'(s), {4'h0, qv[s]});
    for (int s = 6; s < 8; s++) acc(1'b1, tsc_pkg::OUT_CTRL_BASE + 14'(s), 16'h4);
    acc(1'b1, tsc_pkg::BER_START_BASE + 14'h5, 16'h000a);
    acc(1'b1, tsc_pkg::BER_LEN_BASE + 14'h5, 16'h0004);
    // keep the start well clear of a frame so both ends begin together
    @(posedge frame);
    repeat (20) @(posedge bit_clk);
    acc(1'b1, tsc_pkg::BER_CTRL_BASE + 14'h5, 16'h0001);
    arm <= 1'b1;
    @(posedge frame);
    fork
      begin
        for (int i = 0; i < 2048; i++) begin
          @(posedge bit_clk);
          if (i > 0) begin
            for (int s = 0; s < 5; s++) begin
              fb = forced(3'(qv[s] >> (3 * ((i - 1) >> 9))), LVL[s]);
              chk_bit(fwd_data_out[s], fb[7 - ((i - 1) % 8)]);
            end
            chk_bit(sto_out[7], 1'b1);
            if (i < 65) ob[i - 1] = sto_out[6];
          end
        end
        for (int n = 15; n < 64; n++) chk_bit(ob[n], ob[n - 15] ^ ob[n - 14]);
        chk_bit(ob != 64'h0, 1'b1);
        $display("test forcing and output pattern done");
      end
      begin
        repeat (140) @(posedge bit_clk);
        rchk(tsc_pkg::BER_ERR_BASE + 14'h5, 16'h0003);
        arm <= 1'b0;
        acc(1'b1, tsc_pkg::BER_CTRL_BASE + 14'h5, 16'h0000);
        rchk(tsc_pkg::BER_ERR_BASE + 14'h5, 16'h0003);
        err_n <= 4'h0;
        repeat (2) @(posedge bit_clk);
        acc(1'b1, tsc_pkg::BER_CTRL_BASE + 14'h5, 16'h0001);
        arm <= 1'b1;
        @(posedge frame);
        repeat (140) @(posedge bit_clk);
        rchk(tsc_pkg::BER_ERR_BASE + 14'h5, 16'h0000);
        acc(1'b1, tsc_pkg::BER_CTRL_BASE + 14'h5, 16'h0000);
        $display("test error counting done");
      end
    join
    // mid-run reset must clear registers and the registered outputs
    rstn_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    chk(sto_out[15:0] | fwd_data_out[15:0], 16'h0000);
    rstn_in <= 1'b1;
    rchk(tsc_pkg::BER_START_BASE + 14'h5, 16'h0000);
    rchk(tsc_pkg::BER_ERR_BASE + 14'h5, 16'h0000);
    $display("test reset done");
    conclude();
  end
endmodule : tdm_stream_ctrl_ber_receiver_tb
